/* File: rtl/fault_seq_consts.svh */
// Constants for the LED driver fault sequencer.
`ifndef FAULT_SEQ_CONSTS_SVH
`define FAULT_SEQ_CONSTS_SVH
// ==========================================================
// Clock and timing
`define CLK_PERIOD_NS 100
`define MIN_ON_TIME_NS 500
`define MIN_ON_CYCLES ((`MIN_ON_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SKIP_PULSES 4'h8
`define SOA_EVENT_LIMIT 2'h2
`define SHORT_RETRY_LIMIT 2'h2
`define RESTART_SHORT_MS 100
`define RESTART_LONG_MS 1000
`define UV_QUAL_MS 500
`define OOV_QUAL_US 500
`define CYCLES_PER_MS (1000000 / `CLK_PERIOD_NS)
`define CYCLES_PER_US (1000 / `CLK_PERIOD_NS)
`define OOV_QUAL_CYCLES (`OOV_QUAL_US * `CYCLES_PER_US)
// ==========================================================
// Thermal fold-back, temperature in whole degrees
`define TEMP_FOLD_C 8'h91
`define TEMP_SHUT_C 8'hA0
`define TEMP_RECOVER_C 8'h55
`define FOLD_STEP_PERMIL 10'h019
`define FULL_SCALE_PERMIL 10'h3E8
`endif

/* File: rtl/fault_seq_pkg.sv */
// Types shared by the LED driver fault sequencer.
package fault_seq_pkg;
   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_SKIP = 4'b0010,
      ST_RESTART = 4'b0100,
      ST_THERMAL = 4'b1000
   } seq_state_e;
   typedef struct packed {
      logic cycle_start;
      logic switch_on;
      logic peak_reached;
      logic in_blank_end;
      logic current_limit;
      logic line_ov_current;
      logic sense_undervolt;
      logic sense_overvolt;
      logic flywheel;
      logic [7:0] temp_c;
   } sense_flags_s;
   typedef struct packed {
      logic gate_enable;
      logic skipping;
      logic restarting;
      logic thermal_shutdown;
      logic [9:0] current_permil;
   } drive_status_s;
endpackage

/* File: rtl/fault_timer.sv */
// Qualifying timer: pulses once a condition holds for a set number of cycles.
`timescale 1ns/1ps
`default_nettype none
module fault_timer #(
   parameter int unsigned LIMIT = 5000
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_cond,
   output logic o_expired
);
   typedef struct packed {
      logic [31:0] cnt;
      logic fired;
   } timer_s;
   timer_s st_r;
   timer_s st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.fired = 1'b0;
      if (!i_cond) begin
         st_nxt.cnt = 32'h0000_0000; // RQ16
      end else if (st_r.cnt == LIMIT - 1) begin
         st_nxt.cnt = 32'h0000_0000;
         st_nxt.fired = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign o_expired = st_r.fired;
   a_timer_clear: assert property ( // RQ16
      @(posedge i_clk) disable iff (!i_rst_n)
      !i_cond |=> st_r.cnt == 32'h0000_0000)
      else $error("Timer did not clear when condition dropped.");
endmodule // fault_timer
`default_nettype wire

/* File: rtl/restart_timer.sv */
// Auto-restart delay counter, loaded with a cycle count, pulses on expiry.
`timescale 1ns/1ps
`default_nettype none
module restart_timer (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic [31:0] i_cycles,
   output logic o_busy,
   output logic o_done
);
   typedef struct packed {
      logic [31:0] cnt;
      logic busy;
      logic done;
   } rt_s;
   rt_s st_r;
   rt_s st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (i_load) begin
         st_nxt.cnt = i_cycles;
         st_nxt.busy = 1'b1;
      end else if (st_r.busy) begin
         if (st_r.cnt <= 32'h0000_0001) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt - 32'h0000_0001;
         end
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign o_busy = st_r.busy;
   assign o_done = st_r.done;
endmodule // restart_timer
`default_nettype wire

/* File: rtl/fault_sequencer.sv */
// Fault-protection sequencer for a single-stage buck LED driver.
// Behaviour
// (RQ1) Peak current reached within minimum on-time or at blanking end flags safe-area event.
// (RQ2) Each safe-area event suppresses eight following switching cycles.
// (RQ3) A safe-area event puts the device into pulse skipping.
// (RQ4) More than two consecutive safe-area events stop switching for 100 ms.
// (RQ5) After two failed 100 ms retries the restart delay becomes 1 s.
// (RQ6) Sense-pin undervolt held 500 ms triggers a 1 s auto-restart.
// (RQ7) Line overvoltage when sense current exceeds 1 mA during on-time.
// (RQ8) Line overvoltage stops switching at once, then auto-restarts.
// (RQ9) Sense above 2.4 V for 500 us in flywheel triggers auto-restart.
// (RQ10) Internal current limit sends the device into auto-restart.
// (RQ11) Fold-back begins above 145 degrees.
// (RQ12) Current target falls 2.5 percent per degree; shutdown at 160 degrees.
// (RQ13) After thermal shutdown resume only at or below 85 degrees.
// (RQ14) Supply-rail reset clears all logic.
// (RQ15) Switch held off during restart delay; clean cycle clears event counters.
// (RQ16) Fault timers restart from zero when their condition drops early.
`timescale 1ns/1ps
`default_nettype none
`include "fault_seq_consts.svh"
module fault_sequencer #(
   parameter int unsigned UV_QUAL_CYCLES = `UV_QUAL_MS * `CYCLES_PER_MS,
   parameter int unsigned RESTART_SHORT_CYCLES =
      `RESTART_SHORT_MS * `CYCLES_PER_MS,
   parameter int unsigned RESTART_LONG_CYCLES =
      `RESTART_LONG_MS * `CYCLES_PER_MS,
   parameter int unsigned OOV_QUAL_CYCLES = `OOV_QUAL_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire fault_seq_pkg::sense_flags_s i_flags,
   output var fault_seq_pkg::drive_status_s o_status
);
   // ==========================================================
   // Reset release
   // Releasing through two flops keeps the supply-rail reset from
   // ending on an edge that half the state sees and half does not.
   logic [1:0] rst_sync_r;
   logic rst_n;
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_sync_r <= 2'b00; // RQ14
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ==========================================================
   // Fault qualification timers
   // A flag that drops for one cycle starts its timer over, so a
   // chattering comparator can never add up to a fault.
   logic uv_fire;
   logic oov_fire;
   fault_timer #(.LIMIT(UV_QUAL_CYCLES)) u_uv_timer (
      .i_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_cond(i_flags.sense_undervolt), // RQ6
      .o_expired(uv_fire)
   );
   fault_timer #(.LIMIT(OOV_QUAL_CYCLES)) u_oov_timer (
      .i_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_cond(i_flags.sense_overvolt && i_flags.flywheel), // RQ9
      .o_expired(oov_fire)
   );

   // ==========================================================
   // Sequencer state
   typedef struct packed {
      fault_seq_pkg::seq_state_e state;
      logic [3:0] on_cnt;
      logic [3:0] skip_cnt;
      logic [1:0] soa_cnt;
      logic [1:0] retry_cnt;
      logic soa_restart;
      logic restart_load;
      logic [31:0] restart_cycles;
      logic pending_after;
      fault_seq_pkg::drive_status_s status;
   } seq_s;
   seq_s st_r;
   seq_s st_nxt;
   logic rt_busy;
   logic rt_done;
   // The delay counter is loaded one cycle after entry; the extra cycle
   // only lengthens the off time, which errs on the safe side.
   restart_timer u_restart (
      .i_clk(i_ref_clk),
      .i_rst_n(rst_n),
      .i_load(st_r.restart_load),
      .i_cycles(st_r.restart_cycles),
      .o_busy(rt_busy),
      .o_done(rt_done)
   );

   // Fold-back trims the current target only; switching stays on until
   // the shutdown point is reached.
   function automatic logic [9:0] fold_target(input logic [7:0] t);
      logic [7:0] over;
      logic [9:0] drop;
      over = t - `TEMP_FOLD_C;
      drop = 10'(over) * `FOLD_STEP_PERMIL; // RQ12
      if (t <= `TEMP_FOLD_C) begin
         return `FULL_SCALE_PERMIL;
      end
      return `FULL_SCALE_PERMIL - drop;
   endfunction

   logic soa_event;
   logic hard_fault;
   logic over_temp;
   always_comb begin
      soa_event = i_flags.switch_on && i_flags.peak_reached &&
         (st_r.on_cnt < 4'(`MIN_ON_CYCLES) || i_flags.in_blank_end); // RQ1
      hard_fault = (i_flags.switch_on && i_flags.line_ov_current) // RQ7
         || i_flags.current_limit // RQ10
         || oov_fire // RQ9
         || uv_fire; // RQ6
      over_temp = i_flags.temp_c >= `TEMP_SHUT_C;
   end

   // Faults are only acted on in RUN, over-temperature in SKIP as well: while skipping or restarting the
   // gate is already off, so a second fault has nothing to stop.
   always_comb begin
      st_nxt = st_r;
      st_nxt.restart_load = 1'b0;
      if (i_flags.switch_on && st_r.on_cnt != 4'hF) begin
         st_nxt.on_cnt = st_r.on_cnt + 4'h1;
      end else if (!i_flags.switch_on) begin
         st_nxt.on_cnt = 4'h0;
      end
      unique case (st_r.state)
         fault_seq_pkg::ST_RUN: begin
            if (over_temp) begin
               st_nxt.state = fault_seq_pkg::ST_THERMAL; // RQ12
            end else if (hard_fault) begin
               st_nxt.state = fault_seq_pkg::ST_RESTART; // RQ8
               st_nxt.restart_load = 1'b1;
               st_nxt.restart_cycles = uv_fire ?
                  RESTART_LONG_CYCLES : RESTART_SHORT_CYCLES;
               st_nxt.soa_restart = 1'b0;
            end else if (soa_event) begin
               if (st_r.soa_cnt == `SOA_EVENT_LIMIT) begin
                  st_nxt.state = fault_seq_pkg::ST_RESTART; // RQ4
                  st_nxt.restart_load = 1'b1;
                  st_nxt.soa_restart = 1'b1;
                  st_nxt.soa_cnt = 2'h0;
                  if (st_r.retry_cnt == `SHORT_RETRY_LIMIT) begin
                     st_nxt.restart_cycles = RESTART_LONG_CYCLES; // RQ5
                  end else begin
                     st_nxt.restart_cycles = RESTART_SHORT_CYCLES;
                     st_nxt.retry_cnt = st_r.retry_cnt + 2'h1;
                  end
               end else begin
                  st_nxt.soa_cnt = st_r.soa_cnt + 2'h1;
                  st_nxt.state = fault_seq_pkg::ST_SKIP; // RQ3
                  st_nxt.skip_cnt = `SKIP_PULSES;
               end
            end else if (i_flags.cycle_start && st_r.pending_after) begin
               st_nxt.soa_cnt = 2'h0; // RQ15
               st_nxt.retry_cnt = 2'h0;
               st_nxt.pending_after = 1'b0;
            end else if (i_flags.cycle_start) begin
               st_nxt.pending_after = 1'b1;
            end
         end
         fault_seq_pkg::ST_SKIP: begin
            st_nxt.pending_after = 1'b0;
            if (over_temp) begin
               st_nxt.state = fault_seq_pkg::ST_THERMAL;
            end else if (i_flags.cycle_start) begin
               if (st_r.skip_cnt == 4'h1) begin
                  st_nxt.state = fault_seq_pkg::ST_RUN; // RQ2
               end
               st_nxt.skip_cnt = st_r.skip_cnt - 4'h1;
            end
         end
         fault_seq_pkg::ST_RESTART: begin
            st_nxt.pending_after = 1'b0;
            if (rt_done) begin
               st_nxt.state = fault_seq_pkg::ST_RUN; // RQ15
            end
         end
         fault_seq_pkg::ST_THERMAL: begin
            if (i_flags.temp_c <= `TEMP_RECOVER_C) begin
               st_nxt.state = fault_seq_pkg::ST_RUN; // RQ13
            end
         end
         default: begin
            st_nxt.state = fault_seq_pkg::ST_RUN;
         end
      endcase
      st_nxt.status.gate_enable = (st_nxt.state == fault_seq_pkg::ST_RUN);
      st_nxt.status.skipping = (st_nxt.state == fault_seq_pkg::ST_SKIP);
      st_nxt.status.restarting = (st_nxt.state == fault_seq_pkg::ST_RESTART);
      st_nxt.status.thermal_shutdown =
         (st_nxt.state == fault_seq_pkg::ST_THERMAL);
      st_nxt.status.current_permil = fold_target(i_flags.temp_c); // RQ11
   end

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{state: fault_seq_pkg::ST_RUN,
                   status: '{gate_enable: 1'b1,
                             current_permil: `FULL_SCALE_PERMIL,
                             default: '0},
                   default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign o_status = st_r.status;

   // ==========================================================
   // Checks
   // The checks look at the registered status, as the gate driver sees it.
   a_blank_soa: assert property ( // RQ1
      @(posedge i_ref_clk) disable iff (!rst_n)
      st_r.state == fault_seq_pkg::ST_RUN && i_flags.switch_on &&
      i_flags.peak_reached && i_flags.in_blank_end && !hard_fault &&
      !over_temp |=> !o_status.gate_enable)
      else $error("Peak at blanking end did not flag a safe-area event.");
   a_soa_skip: assert property ( // RQ2
      @(posedge i_ref_clk) disable iff (!rst_n)
      st_r.state == fault_seq_pkg::ST_RUN && soa_event && !hard_fault &&
      !over_temp && st_r.soa_cnt != `SOA_EVENT_LIMIT
      |=> st_r.skip_cnt == `SKIP_PULSES && o_status.skipping)
      else $error("Safe-area event did not start eight-cycle skip.");
   a_skip_gate_off: assert property ( // RQ3
      @(posedge i_ref_clk) disable iff (!rst_n)
      o_status.skipping |-> !o_status.gate_enable)
      else $error("Gate enabled while skipping.");
   a_soa_restart: assert property ( // RQ4
      @(posedge i_ref_clk) disable iff (!rst_n)
      st_r.state == fault_seq_pkg::ST_RUN && soa_event && !hard_fault &&
      !over_temp && st_r.soa_cnt == `SOA_EVENT_LIMIT
      |=> o_status.restarting ##1 rt_busy)
      else $error("Third safe-area event did not start restart.");
   a_long_delay: assert property ( // RQ5
      @(posedge i_ref_clk) disable iff (!rst_n)
      st_r.restart_load && st_r.soa_restart &&
      $past(st_r.retry_cnt) == `SHORT_RETRY_LIMIT
      |-> st_r.restart_cycles == RESTART_LONG_CYCLES)
      else $error("Restart delay not lengthened after two retries.");
   a_uv_long: assert property ( // RQ6
      @(posedge i_ref_clk) disable iff (!rst_n)
      uv_fire && st_r.state == fault_seq_pkg::ST_RUN && !over_temp
      |=> st_r.restart_cycles == RESTART_LONG_CYCLES)
      else $error("Undervoltage did not select long restart.");
   a_line_ov_stop: assert property ( // RQ8
      @(posedge i_ref_clk) disable iff (!rst_n)
      i_flags.switch_on && i_flags.line_ov_current &&
      st_r.state == fault_seq_pkg::ST_RUN && !over_temp
      |=> !o_status.gate_enable && o_status.restarting)
      else $error("Line overvoltage did not stop switching.");
   a_oov_restart: assert property ( // RQ9
      @(posedge i_ref_clk) disable iff (!rst_n)
      oov_fire && !uv_fire && st_r.state == fault_seq_pkg::ST_RUN &&
      !over_temp |=> o_status.restarting &&
      st_r.restart_cycles == RESTART_SHORT_CYCLES)
      else $error("Output overvoltage did not start a short restart.");
   a_ilim_restart: assert property ( // RQ10
      @(posedge i_ref_clk) disable iff (!rst_n)
      i_flags.current_limit && st_r.state == fault_seq_pkg::ST_RUN &&
      !over_temp |=> o_status.restarting)
      else $error("Current limit did not trigger restart.");
   a_fold_full: assert property ( // RQ11
      @(posedge i_ref_clk) disable iff (!rst_n)
      i_flags.temp_c <= `TEMP_FOLD_C
      |=> o_status.current_permil == `FULL_SCALE_PERMIL)
      else $error("Fold-back active at or below threshold.");
   a_fold_step: assert property ( // RQ12
      @(posedge i_ref_clk) disable iff (!rst_n)
      i_flags.temp_c > `TEMP_FOLD_C && i_flags.temp_c < `TEMP_SHUT_C
      |=> 16'(o_status.current_permil) +
         16'($past(i_flags.temp_c) - `TEMP_FOLD_C) * 16'h0019 == 16'h03E8)
      else $error("Fold-back current not 2.5 percent per degree.");
   a_otp_hold: assert property ( // RQ13
      @(posedge i_ref_clk) disable iff (!rst_n)
      o_status.thermal_shutdown && i_flags.temp_c > `TEMP_RECOVER_C
      |=> o_status.thermal_shutdown)
      else $error("Left thermal shutdown above recovery point.");
   a_restart_off: assert property ( // RQ15
      @(posedge i_ref_clk) disable iff (!rst_n)
      rt_busy |-> !o_status.gate_enable)
      else $error("Gate enabled during restart delay.");
   a_retry_after: assert property ( // RQ15
      @(posedge i_ref_clk) disable iff (!rst_n)
      rt_done && st_r.state == fault_seq_pkg::ST_RESTART
      |=> o_status.gate_enable)
      else $error("Switching did not resume after restart delay.");
   c_skip: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
      o_status.skipping ##1 o_status.gate_enable);
   c_restart: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
      rt_done);
   c_thermal: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
      o_status.thermal_shutdown ##1 o_status.gate_enable);
   c_oov: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
      oov_fire);
   c_blank_soa: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
      i_flags.in_blank_end && soa_event);
endmodule // fault_sequencer
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking testbench for the LED driver fault sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, a) begin \
   num_checks++; \
   if ((a) !== (e)) begin \
      mismatches++; \
      $display("mismatch t=%0t exp=%h act=%h", $time, e, a); \
   end \
end
module testbench;
   // =========================================================
   // Setup
   localparam int SHORT = 10;
   localparam int LONG = 30;
   localparam int GATE = 0;
   localparam int SKIP = 1;
   localparam int RST = 2;
   localparam int SHUT = 3;
   localparam int PERMIL = 4;
   localparam int RANGE = 5;
   typedef struct {logic [9:0] v; int f;} note_s;
   logic ref_clk;
   logic reset_n;
   fault_seq_pkg::sense_flags_s flags;
   fault_seq_pkg::drive_status_s status;
   note_s notes[$];
   event chk;
   int mismatches = 0;
   int num_checks = 0;
   int run_len = 0;
   int last_run = 0;
   int gate_bad = 0;
   logic in_range = 1'b0;
   int t;

   // Short delays keep the run far below the real 100 ms and 1 s spans.
   fault_sequencer #(
      .UV_QUAL_CYCLES(20),
      .RESTART_SHORT_CYCLES(SHORT),
      .RESTART_LONG_CYCLES(LONG),
      .OOV_QUAL_CYCLES(15)
   ) uut (
      .i_ref_clk(ref_clk),
      .i_reset_n(reset_n),
      .i_flags(flags),
      .o_status(status)
   );

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Length of each restart window, and any gate activity inside it.
   always @(negedge ref_clk) begin
      if (status.restarting === 1'b1) begin
         run_len++;
         if (status.gate_enable !== 1'b0) gate_bad++;
      end else begin
         if (run_len > 0) last_run = run_len;
         run_len = 0;
      end
   end

   // =========================================================
   // Checking
   initial begin
      note_s n;
      logic [9:0] a;
      forever begin
         @(chk);
         n = notes.pop_front();
         case (n.f)
            GATE: a = 10'(status.gate_enable);
            SKIP: a = 10'(status.skipping);
            RST: a = 10'(status.restarting);
            SHUT: a = 10'(status.thermal_shutdown);
            RANGE: a = 10'(in_range);
            default: a = status.current_permil;
         endcase
         `CHK(n.v, a)
      end
   end

   task automatic expect_f(input int f, input logic [9:0] v);
      notes.push_back('{v: v, f: f});
      ->chk;
      #1;
   endtask

   task automatic print_verdict();
      if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge ref_clk);
      mismatches++;
      print_verdict();
   end

   // =========================================================
   // Stimulus
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         flags.cycle_start = 1'b1;
         cyc(1);
         flags.cycle_start = 1'b0;
         cyc(2);
      end
   endtask

   // Peak current one cycle into the on-time, well inside 500 ns.
   task automatic safe_area_fault();
      flags.cycle_start = 1'b1;
      flags.switch_on = 1'b1;
      cyc(1);
      flags.cycle_start = 1'b0;
      flags.peak_reached = 1'b1;
      cyc(1);
      flags.peak_reached = 1'b0;
      flags.switch_on = 1'b0;
      cyc(3);
   endtask

   task automatic burst();
      repeat (3) begin
         safe_area_fault();
         if (status.restarting === 1'b1) break;
         pulses(8);
      end
   endtask

   task automatic wait_done(input int lo, input int hi);
      int c;
      c = 0;
      while (status.restarting !== 1'b1 && c < 40) begin
         cyc(1);
         c++;
      end
      while (status.restarting === 1'b1 && c < 400) begin
         cyc(1);
         c++;
      end
      cyc(1);
      in_range = (last_run >= lo && last_run <= hi && gate_bad == 0);
      gate_bad = 0;
   endtask

   initial begin
      void'($urandom(53174));
      reset_n = 1'b0;
      flags = '0;
      flags.temp_c = 8'h19;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      reset_n = 1'b1;
      cyc(3);
      expect_f(GATE, 10'h001);
      expect_f(PERMIL, 10'h3E8);
      safe_area_fault();
      expect_f(SKIP, 10'h001);
      expect_f(GATE, 10'h000);
      pulses(7);
      expect_f(SKIP, 10'h001);
      pulses(1);
      expect_f(GATE, 10'h001);
      expect_f(SKIP, 10'h000);
      for (int r = 0; r < 3; r++) begin
         burst();
         if (r == 2) wait_done(LONG - 1, LONG + 3);
         else wait_done(SHORT - 1, SHORT + 3);
         expect_f(RANGE, 10'h001);
      end
      pulses(3);
      safe_area_fault();
      expect_f(RST, 10'h000);
      expect_f(SKIP, 10'h001);
      pulses(11);
      burst();
      wait_done(SHORT - 1, SHORT + 3);
      expect_f(RANGE, 10'h001);
      flags.switch_on = 1'b1;
      flags.line_ov_current = 1'b1;
      cyc(2);
      expect_f(GATE, 10'h000);
      flags.switch_on = 1'b0;
      flags.line_ov_current = 1'b0;
      wait_done(SHORT - 1, SHORT + 3);
      expect_f(RANGE, 10'h001);
      pulses(3);
      flags.current_limit = 1'b1;
      cyc(2);
      expect_f(RST, 10'h001);
      flags.current_limit = 1'b0;
      wait_done(SHORT - 1, SHORT + 3);
      pulses(3);
      // Overvoltage outside the flywheel time must not count.
      flags.sense_overvolt = 1'b1;
      cyc(20);
      expect_f(RST, 10'h000);
      flags.flywheel = 1'b1;
      cyc(12);
      flags.sense_overvolt = 1'b0;
      cyc(1);
      flags.sense_overvolt = 1'b1;
      cyc(12);
      expect_f(RST, 10'h000);
      cyc(8);
      flags.sense_overvolt = 1'b0;
      flags.flywheel = 1'b0;
      wait_done(SHORT - 1, SHORT + 3);
      expect_f(RANGE, 10'h001);
      pulses(3);
      flags.sense_undervolt = 1'b1;
      cyc(15);
      flags.sense_undervolt = 1'b0;
      cyc(1);
      flags.sense_undervolt = 1'b1;
      cyc(15);
      expect_f(RST, 10'h000);
      cyc(10);
      flags.sense_undervolt = 1'b0;
      wait_done(LONG - 1, LONG + 3);
      expect_f(RANGE, 10'h001);
      pulses(3);
      flags.temp_c = 8'h91;
      cyc(3);
      expect_f(PERMIL, 10'h3E8);
      repeat (5) begin
         t = 146 + int'($urandom % 14);
         flags.temp_c = 8'(t);
         cyc(3);
         expect_f(PERMIL, 10'(1000 - 25 * (t - 145)));
      end
      flags.temp_c = 8'hA0;
      cyc(3);
      expect_f(SHUT, 10'h001);
      expect_f(GATE, 10'h000);
      flags.temp_c = 8'h56;
      cyc(3);
      expect_f(SHUT, 10'h001);
      flags.temp_c = 8'h55;
      cyc(3);
      expect_f(SHUT, 10'h000);
      expect_f(GATE, 10'h001);
      flags.temp_c = 8'h19;
      pulses(3);
      // Peak after the minimum on-time counts only at blanking end.
      flags.switch_on = 1'b1;
      cyc(6);
      flags.peak_reached = 1'b1;
      cyc(1);
      flags.peak_reached = 1'b0;
      expect_f(SKIP, 10'h000);
      flags.in_blank_end = 1'b1;
      flags.peak_reached = 1'b1;
      cyc(1);
      flags.switch_on = 1'b0;
      flags.peak_reached = 1'b0;
      flags.in_blank_end = 1'b0;
      cyc(1);
      expect_f(SKIP, 10'h001);
      pulses(3);
      safe_area_fault();
      reset_n = 1'b0;
      cyc(1);
      expect_f(SKIP, 10'h000);
      expect_f(GATE, 10'h001);
      reset_n = 1'b1;
      cyc(4);
      safe_area_fault();
      expect_f(SKIP, 10'h001);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
